// ### ovf_pkg.sv
// Constants and types for the input overvoltage fault-response block
// Overview of operation
// - Action register is host byte read/write
// - Code 00: ignore fault, keep output running
// - Code 01: run for delay, then retry setting
// - Code 10: disable output, then follow retries
// - Code 11: stay off until fault cleared
// - Retry 000: never restart, stay off
// - Retry 1-3: that many attempts, then off
// - Retry 4-6: that many attempts, then off
// - Retry 111: retry until commanded off
// - Attempt spacing is delay count times unit
// - Delay count is two to field value
`default_nettype none
package ovf_pkg;
  // Command code of the fault action register
  localparam logic [7:0] CMD_FAULT_ACTION   = 8'h56;
  localparam logic [7:0] FAULT_ACTION_RESET = 8'hC0;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY  = 2'h1;
  localparam logic [1:0] RESP_RETRY  = 2'h2;
  localparam logic [1:0] RESP_LATCH  = 2'h3;

  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Delay count is one unit shifted left by the field value
  localparam logic [7:0] DELAY_ONE_UNIT = 8'h01;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_GRACE,
    ST_WAIT,
    ST_LATCH
  } ovf_state_e;
endpackage
`default_nettype wire

// ### ovf_delay_timer.sv
// Delay timer counting delay-unit ticks up to two to the field value
`timescale 1ns/100ps
`default_nettype none
module ovf_delay_timer (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [2:0] delay_exp,
  input  wire logic       unit_tick,
  output logic            done_q
);
  logic [7:0] cnt_q;
  logic [7:0] target_q;
  logic       run_q;
  wire  [7:0] cnt_inc  = cnt_q + 8'h01;
  wire        last_tck = run_q && unit_tick && (cnt_inc == target_q);

  // Target is captured at start so a register write cannot stretch a wait
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_q    <= 8'h00;
      target_q <= ovf_pkg::DELAY_ONE_UNIT;
      run_q    <= 1'b0;
      done_q   <= 1'b0;
    end else if (abort) begin
      cnt_q  <= 8'h00;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q    <= 8'h00;
      target_q <= ovf_pkg::DELAY_ONE_UNIT << delay_exp;
      run_q    <= 1'b1;
      done_q   <= 1'b0;
    end else begin
      done_q <= last_tck;
      if (last_tck) begin
        run_q <= 1'b0;
      end else if (run_q && unit_tick) begin
        cnt_q <= cnt_inc;
      end
    end
  end

  interval_end_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (last_tck && !abort && !start) |=> done_q)
    else $error("delay timer missed its last unit");
  interval_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    done_q |-> ($past(cnt_inc) == $past(target_q)))
    else $error("delay timer ended on wrong unit count");
endmodule // ovf_delay_timer
`default_nettype wire

// ### ovf_fault_action.sv
// Input overvoltage fault-response controller with its action register
`timescale 1ns/100ps
`default_nettype none
module ovf_fault_action (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [7:0] cmd_code,
  input  wire logic       wr_byte_stb,
  input  wire logic [7:0] wr_byte,
  input  wire logic       rd_byte_stb,
  output logic      [7:0] rd_byte_q,
  output logic            rd_valid_q,
  input  wire logic       vin_ov_fault,
  input  wire logic       unit_tick,
  input  wire logic       clear_fault_stb,
  input  wire logic       on_cmd,
  input  wire logic       other_shutdown,
  output logic            out_en_q,
  output logic            fault_flag_q,
  output logic            latched_off_q,
  output logic      [2:0] retry_cnt_q
);
  logic [7:0]             action_q;
  logic                   on_prev_q;
  ovf_pkg::ovf_state_e    state_q;
  ovf_pkg::ovf_state_e    state_d;
  logic [2:0]             retry_cnt_d;
  logic                   start_t;
  logic                   timer_done;

  // Register decode
  wire       reg_hit = (cmd_code == ovf_pkg::CMD_FAULT_ACTION);
  wire       wr_hit  = wr_byte_stb && reg_hit;
  wire       rd_hit  = rd_byte_stb && reg_hit;
  wire [7:0] rd_mux  = rd_hit ? action_q : ovf_pkg::UNMAPPED_READ;

  // Field decode
  wire [1:0] resp    = action_q[ovf_pkg::RESP_MSB:ovf_pkg::RESP_LSB];
  wire [2:0] retries = action_q[ovf_pkg::RETRY_MSB:ovf_pkg::RETRY_LSB];
  wire [2:0] dly_exp = action_q[ovf_pkg::DELAY_MSB:ovf_pkg::DELAY_LSB];

  // Off-then-on through the enable command counts as a fault clear
  wire on_rise   = on_cmd && !on_prev_q;
  wire clear_evt = clear_fault_stb || on_rise;
  wire run_ok    = on_cmd && !other_shutdown;
  // A clear in RUN may start a fresh wait; it must not abort that start
  wire abort_t   = !run_ok || (clear_evt && !start_t);

  // Counter holds at its top value so unlimited retry cannot wrap
  wire [2:0] cnt_inc = (retry_cnt_q == 3'h7) ? retry_cnt_q
                                             : retry_cnt_q + 3'h1;

  function automatic logic attempts_used(input logic [2:0] limit,
                                         input logic [2:0] used);
    attempts_used = (limit != ovf_pkg::RETRY_FOREVER) && (used >= limit);
  endfunction

  wire shut_latch = (retries == ovf_pkg::RETRY_NONE);
  wire give_up    = attempts_used(retries, cnt_inc);

  ovf_delay_timer u_timer (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .start     (start_t),
    .abort     (abort_t),
    .delay_exp (dly_exp),
    .unit_tick (unit_tick),
    .done_q    (timer_done)
  );

  always_comb begin
    state_d     = state_q;
    retry_cnt_d = retry_cnt_q;
    start_t     = 1'b0;
    case (state_q)
      ovf_pkg::ST_OFF: begin
        retry_cnt_d = 3'h0;
        state_d     = ovf_pkg::ST_RUN;
      end
      ovf_pkg::ST_RUN: begin
        if (vin_ov_fault) begin
          retry_cnt_d = 3'h0;
          case (resp)
            ovf_pkg::RESP_IGNORE: state_d = ovf_pkg::ST_RUN;
            ovf_pkg::RESP_DELAY: begin
              state_d = ovf_pkg::ST_GRACE;
              start_t = 1'b1;
            end
            ovf_pkg::RESP_RETRY: begin
              state_d = shut_latch ? ovf_pkg::ST_LATCH
                                   : ovf_pkg::ST_WAIT;
              start_t = !shut_latch;
            end
            default: state_d = ovf_pkg::ST_LATCH;
          endcase
        end
      end
      ovf_pkg::ST_GRACE: begin
        if (timer_done && !vin_ov_fault) begin
          state_d = ovf_pkg::ST_RUN;
        end else if (timer_done) begin
          state_d = shut_latch ? ovf_pkg::ST_LATCH
                               : ovf_pkg::ST_WAIT;
          start_t = !shut_latch;
        end
      end
      ovf_pkg::ST_WAIT: begin
        if (timer_done) begin
          retry_cnt_d = cnt_inc;
          if (!vin_ov_fault) begin
            state_d = ovf_pkg::ST_RUN;
          end else if (give_up) begin
            state_d = ovf_pkg::ST_LATCH;
          end else begin
            start_t = 1'b1;
          end
        end
      end
      default: ;
    endcase
    // A clear restarts the whole sequence from scratch
    if (clear_evt && state_q != ovf_pkg::ST_RUN) begin
      state_d     = ovf_pkg::ST_RUN;
      retry_cnt_d = 3'h0;
      start_t     = 1'b0;
    end
    // A latched fault outlives a shutdown; only a clear, off-on or reset frees it
    if (!run_ok && state_d != ovf_pkg::ST_LATCH) begin
      state_d     = ovf_pkg::ST_OFF;
      retry_cnt_d = 3'h0;
      start_t     = 1'b0;
    end
  end

  wire out_en_d = (state_d == ovf_pkg::ST_RUN) ||
                  (state_d == ovf_pkg::ST_GRACE);
  // A fault present in the clearing cycle keeps the flag set
  wire flag_d   = vin_ov_fault || (fault_flag_q && !clear_evt);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      action_q <= ovf_pkg::FAULT_ACTION_RESET;
    end else if (wr_hit) begin
      action_q <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_byte_q  <= ovf_pkg::UNMAPPED_READ;
      rd_valid_q <= 1'b0;
    end else begin
      rd_byte_q  <= rd_mux;
      rd_valid_q <= rd_byte_stb;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q       <= ovf_pkg::ST_OFF;
      retry_cnt_q   <= 3'h0;
      // Enable idles high, so this avoids a false rise after reset
      on_prev_q     <= 1'b1;
      out_en_q      <= 1'b0;
      fault_flag_q  <= 1'b0;
      latched_off_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      retry_cnt_q   <= retry_cnt_d;
      on_prev_q     <= on_cmd;
      out_en_q      <= out_en_d;
      fault_flag_q  <= flag_d;
      latched_off_q <= (state_d == ovf_pkg::ST_LATCH);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  reg_write_a: assert property (wr_hit |=>
    (action_q == $past(wr_byte)))
    else $error("action register did not take the written byte");
  reg_read_a: assert property (rd_hit |=>
    (rd_valid_q && rd_byte_q == $past(action_q)))
    else $error("action register read returned wrong byte");
  ignore_run_a: assert property ((state_q == ovf_pkg::ST_RUN &&
    resp == ovf_pkg::RESP_IGNORE && run_ok) |=> out_en_q [*2])
    else $error("ignored fault interrupted the output");
  grace_end_a: assert property ((state_q == ovf_pkg::ST_GRACE &&
    timer_done && vin_ov_fault && run_ok && !clear_evt) |=> !out_en_q)
    else $error("output still on after grace delay with fault");
  retry_off_a: assert property ((state_q == ovf_pkg::ST_RUN &&
    resp == ovf_pkg::RESP_RETRY && vin_ov_fault && run_ok) |=> !out_en_q)
    else $error("disable-and-retry did not disable output");
  latch_hold_a: assert property ((state_q == ovf_pkg::ST_LATCH &&
    !clear_evt && run_ok) |=> (latched_off_q && !out_en_q))
    else $error("latched fault released without a clear");
  no_retry_a: assert property ((state_q == ovf_pkg::ST_RUN &&
    resp == ovf_pkg::RESP_RETRY && shut_latch && vin_ov_fault &&
    run_ok) |=> latched_off_q)
    else $error("zero retry setting did not latch off");
  retry_limit_a: assert property ((state_q == ovf_pkg::ST_WAIT &&
    timer_done && vin_ov_fault && give_up && run_ok && !clear_evt)
    |=> (latched_off_q && retry_cnt_q == $past(retries)))
    else $error("retry limit not honoured");
  retry_forever_a: assert property ((state_q == ovf_pkg::ST_WAIT &&
    retries == ovf_pkg::RETRY_FOREVER && run_ok && !clear_evt)
    |=> !latched_off_q)
    else $error("unlimited retry latched off");
  clear_fresh_a: assert property ((clear_evt && run_ok &&
    state_q != ovf_pkg::ST_RUN) |=> (retry_cnt_q == 3'h0 && !latched_off_q))
    else $error("clear did not restart the retry sequence");
  run_gate_a: assert property (!run_ok |=> !out_en_q)
    else $error("output stayed on while commanded off");
  flag_set_a: assert property (vin_ov_fault |=> fault_flag_q)
    else $error("fault status bit missed a fault");

  grace_ok_c: cover property (state_q == ovf_pkg::ST_GRACE && timer_done
    && !vin_ov_fault);
  retry_win_c: cover property (state_q == ovf_pkg::ST_WAIT && timer_done
    && !vin_ov_fault && retry_cnt_q != 3'h0);
  latch_c: cover property ($rose(latched_off_q) ##[1:200] clear_evt);
endmodule // ovf_fault_action
`default_nettype wire

// ### ovf_host_model.sv
// Behavioural system host issuing byte transfers to the fault block
`timescale 1ns/100ps
`default_nettype none
module ovf_host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] cmd_code,
  output logic            wr_byte_stb,
  output logic      [7:0] wr_byte,
  output logic            rd_byte_stb,
  input  wire logic [7:0] rd_byte_q,
  input  wire logic       rd_valid_q
);
  initial begin
    cmd_code = 8'h00;
    wr_byte_stb = 1'b0;
    wr_byte = 8'h00;
    rd_byte_stb = 1'b0;
  end
  // Single byte write, strobe stands one cycle
  task automatic write_byte(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk_sys);
    cmd_code = c;
    wr_byte = d;
    wr_byte_stb = 1'b1;
    @(negedge clk_sys);
    wr_byte_stb = 1'b0;
    // Released data shows the inverse so a stale byte is never reused
    wr_byte = ~d;
  endtask
  // Single byte read, answer sampled one cycle after the strobe
  task automatic read_byte(input logic [7:0] c, output logic [7:0] d);
    @(negedge clk_sys);
    cmd_code = c;
    rd_byte_stb = 1'b1;
    @(negedge clk_sys);
    rd_byte_stb = 1'b0;
    d = (rd_valid_q === 1'b1) ? rd_byte_q : 8'hEE;
  endtask
endmodule // ovf_host_model
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the fault-response controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] cmd_code, wr_byte, rd_byte_q, rd;
  logic       wr_byte_stb, rd_byte_stb, rd_valid_q;
  logic       vin_ov_fault = 1'b0;
  logic       unit_tick = 1'b0;
  logic       clear_fault_stb = 1'b0;
  logic       on_cmd = 1'b1;
  logic       other_shutdown = 1'b0;
  logic       out_en_q, fault_flag_q, latched_off_q;
  logic [2:0] retry_cnt_q;
  int         err_count = 0;
  int         checks = 0;

  always #4 clk_sys = ~clk_sys;

  ovf_host_model host (.clk_sys(clk_sys), .cmd_code(cmd_code),
    .wr_byte_stb(wr_byte_stb), .wr_byte(wr_byte), .rd_byte_stb(rd_byte_stb),
    .rd_byte_q(rd_byte_q), .rd_valid_q(rd_valid_q));

  ovf_fault_action DUT (.clk_sys(clk_sys), .rstn(rstn), .cmd_code(cmd_code),
    .wr_byte_stb(wr_byte_stb), .wr_byte(wr_byte), .rd_byte_stb(rd_byte_stb),
    .rd_byte_q(rd_byte_q), .rd_valid_q(rd_valid_q),
    .vin_ov_fault(vin_ov_fault), .unit_tick(unit_tick),
    .clear_fault_stb(clear_fault_stb), .on_cmd(on_cmd),
    .other_shutdown(other_shutdown), .out_en_q(out_en_q),
    .fault_flag_q(fault_flag_q), .latched_off_q(latched_off_q),
    .retry_cnt_q(retry_cnt_q));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      unit_tick = 1'b1;
      @(negedge clk_sys);
      unit_tick = 1'b0;
    end
  endtask
  // Drops the fault first so the clear is not undone at once
  task automatic clear_all();
    vin_ov_fault = 1'b0;
    @(negedge clk_sys);
    clear_fault_stb = 1'b1;
    @(negedge clk_sys);
    clear_fault_stb = 1'b0;
    cyc(3);
    `CHK(out_en_q, 1'b1)
    `CHK(retry_cnt_q, 3'h0)
  endtask
  task automatic t_reg();
    host.read_byte(8'h56, rd);
    `CHK(rd, 8'hC0)
    host.write_byte(8'h56, 8'h9A);
    host.write_byte(8'h57, 8'h11);
    host.read_byte(8'h56, rd);
    `CHK(rd, 8'h9A)
    host.read_byte(8'h57, rd);
    `CHK(rd, 8'h00)
  endtask
  task automatic t_ignore();
    host.write_byte(8'h56, 8'h00);
    vin_ov_fault = 1'b1;
    tick(3);
    `CHK(out_en_q, 1'b1)
    `CHK(fault_flag_q, 1'b1)
    clear_all();
  endtask
  task automatic t_delay();
    host.write_byte(8'h56, 8'h49);
    vin_ov_fault = 1'b1;
    tick(1);
    cyc(3);
    `CHK(out_en_q, 1'b1)
    tick(1);
    cyc(3);
    `CHK(out_en_q, 1'b0)
    tick(1);
    cyc(3);
    `CHK(latched_off_q, 1'b0)
    tick(1);
    cyc(3);
    `CHK(latched_off_q, 1'b1)
    `CHK(retry_cnt_q, 3'h1)
    clear_all();
  endtask
  task automatic t_six();
    host.write_byte(8'h56, 8'hB0);
    vin_ov_fault = 1'b1;
    cyc(2);
    `CHK(out_en_q, 1'b0)
    for (int i = 1; i <= 6; i++) begin
      tick(1);
      cyc(3);
      `CHK(retry_cnt_q, 3'(i))
      `CHK(latched_off_q, 1'(i == 6))
    end
    clear_all();
  endtask
  task automatic t_none_latch();
    host.write_byte(8'h56, 8'h80);
    vin_ov_fault = 1'b1;
    cyc(3);
    `CHK(latched_off_q, 1'b1)
    vin_ov_fault = 1'b0;
    tick(2);
    `CHK(out_en_q, 1'b0)
    clear_all();
    host.write_byte(8'h56, 8'hC8);
    vin_ov_fault = 1'b1;
    cyc(2);
    vin_ov_fault = 1'b0;
    tick(3);
    `CHK(out_en_q, 1'b0)
    on_cmd = 1'b0;
    cyc(2);
    on_cmd = 1'b1;
    cyc(3);
    `CHK(out_en_q, 1'b1)
    `CHK(fault_flag_q, 1'b0)
  endtask
  // Bias power loss is modelled by a reset in mid-run
  task automatic t_bias_loss();
    host.write_byte(8'h56, 8'hC8);
    vin_ov_fault = 1'b1;
    cyc(3);
    `CHK(latched_off_q, 1'b1)
    vin_ov_fault = 1'b0;
    rstn = 1'b0;
    cyc(2);
    `CHK(out_en_q, 1'b0)
    rstn = 1'b1;
    cyc(2);
    `CHK(latched_off_q, 1'b0)
    `CHK(out_en_q, 1'b1)
    host.read_byte(8'h56, rd);
    `CHK(rd, ovf_pkg::FAULT_ACTION_RESET)
  endtask
  task automatic t_forever();
    host.write_byte(8'h56, 8'hB8);
    vin_ov_fault = 1'b1;
    tick(9);
    cyc(2);
    `CHK(latched_off_q, 1'b0)
    vin_ov_fault = 1'b0;
    tick(1);
    cyc(3);
    `CHK(out_en_q, 1'b1)
    other_shutdown = 1'b1;
    cyc(2);
    `CHK(out_en_q, 1'b0)
    other_shutdown = 1'b0;
  endtask
  task automatic results();
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    cyc(20);
    rstn = 1'b1;
    cyc(2);
    t_reg();
    t_ignore();
    t_delay();
    t_six();
    t_none_latch();
    t_forever();
    t_bias_loss();
    results();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #40000;
    err_count++;
    results();
  end
endmodule // tb_top
`default_nettype wire
